// *** rtl/local_switch_map_pkg.sv ***
package local_switch_map_pkg;

  // ----------------------------------------------------------------
  // Map geometry and entry field positions
  // ----------------------------------------------------------------
  localparam int unsigned MAP_ENTRIES    = 4096;
  localparam int unsigned MAP_IDX_W      = 12;
  localparam int unsigned ENTRY_W        = 16;
  localparam int unsigned ADDR_W         = 14;
  localparam int unsigned SRC_BIT        = 15;
  localparam int unsigned MSG_BIT        = 14;
  localparam int unsigned ON_BIT         = 13;
  localparam int unsigned LOW_STREAM_HI  = 12;
  localparam int unsigned LOW_STREAM_LO  = 8;
  localparam int unsigned TOP_STREAM_LO  = 9;
  localparam int unsigned ADDR_STREAM_LO = 9;
  localparam logic [4:0]  STREAM_LIMIT   = 5'h0f;
  localparam logic [4:0]  TOP_STREAM_MAX = 5'h07;
  localparam logic [8:0]  LOW_CHAN_MAX   = 9'h0ff;
  localparam logic [3:0]  BITS_PER_SLOT  = 4'h8;
  localparam logic [15:0] MAP_RESET      = 16'h0000;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              rd;
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [15:0]       wdata;
  } host_req_t;

  typedef struct packed {
    logic       valid;
    logic       fetch;
    logic       msg;
    logic       local_src;
    logic       src_top;
    logic       drive;
    logic [4:0] stream;
    logic [8:0] chan;
    logic [7:0] msg_byte;
  } conn_t;

  typedef struct packed {
    logic        fm_s1;
    logic        fm_s2;
    logic        hrd_v;
    logic        hrd_ok;
    logic        rd_ack;
    logic [15:0] rd_data;
    logic        lk_v;
    logic        lk_bad;
    conn_t       conn;
  } map_state_t;

  typedef struct packed {
    logic [7:0] sr;
    logic [3:0] left;
    logic       oe;
    logic       ext_off;
  } shift_state_t;

endpackage

// *** rtl/slot_shifter.sv ***
`timescale 1ns/1ns
module slot_shifter
  import local_switch_map_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       load,
  input  wire logic [7:0] load_byte,
  input  wire logic       load_drive,
  input  wire logic       float_mode,
  input  wire logic       bit_tick,
  output logic            ser_data,
  output logic            ser_oe,
  output logic            ext_buf_off
);
  import local_switch_map_pkg::*;

  shift_state_t q;
  shift_state_t d;

  always_comb begin
    d = q;
    if (load) begin
      d.sr      = load_byte;
      d.left    = BITS_PER_SLOT;
      // A floated channel either releases the pin or keeps it and tells the external buffer.
      d.oe      = load_drive | float_mode;
      d.ext_off = ~load_drive & float_mode;
    end else if (bit_tick && q.left != 4'h0) begin
      d.sr   = {q.sr[6:0], 1'b0};
      d.left = q.left - 4'h1;
      if (q.left == 4'h1) begin
        d.oe      = 1'b0;
        d.ext_off = 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign ser_data    = q.sr[7];
  assign ser_oe      = q.oe;
  assign ext_buf_off = q.ext_off;

endmodule

// *** rtl/local_switch_map.sv ***
// Operation
// - One 4,096-entry map of 16-bit words, one word per output stream/channel.
// - Host address bits 13..0 select the entry as stream and channel.
// - Entry layout depends on whether the chosen source runs at 32 Mbps.
// - Bit 15 low takes backplane data, high takes local data.
// - Message mode ignores source port choice and source stream field.
// - Bit 14 low is connection mode, high is message mode.
// - Message mode sends the entry low byte on the output stream.
// - Bit 13 low floats the channel per float mode pin; high drives, except where the source stream or the target slot is out of range.
// - Below 32 Mbps, bits 12..8 are the five-bit source stream.
// - Below 32 Mbps in connection mode, bits 7..0 are the source channel.
// - Message byte is shifted out bit 7 first, bit 0 last.
// - At 32 Mbps, bits 12..9 are the four-bit source stream.
// - At 32 Mbps, bits 8..0 are the channel; bits 7..0 carry messages.
// - A side at 32 Mbps uses streams 0 to 7 only.
`timescale 1ns/1ns
module local_switch_map
  import local_switch_map_pkg::*;
(
  input  wire logic                     clock,
  input  wire logic                     rst_n,
  input  wire local_switch_map_pkg::host_req_t host,
  output logic                          rd_ack,
  output logic [15:0]                   rd_data,
  input  wire logic                     out_top_rate,
  input  wire logic                     bp_top_rate,
  input  wire logic                     lo_top_rate,
  input  wire logic                     slot_req,
  input  wire logic [3:0]               slot_stream,
  input  wire logic [8:0]               slot_chan,
  output local_switch_map_pkg::conn_t   conn,
  input  wire logic [7:0]               sw_data,
  input  wire logic                     bit_tick,
  input  wire logic                     output_float_mode_pin,
  output logic                          ser_data,
  output logic                          ser_oe,
  output logic                          ext_buf_off
);
  import local_switch_map_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [MAP_IDX_W-1:0] map_index(input logic [4:0] stream, input logic [8:0] chan,
                                                     input logic top);
    map_index = top ? {stream[2:0], chan} : {stream[3:0], chan[7:0]};
  endfunction

  function automatic logic map_ok(input logic [4:0] stream, input logic [8:0] chan, input logic top);
    map_ok = top ? (stream <= TOP_STREAM_MAX) : (stream <= STREAM_LIMIT && chan <= LOW_CHAN_MAX);
  endfunction

  function automatic conn_t decode(input logic [15:0] e, input logic bp_top, input logic lo_top,
                                   input logic v, input logic bad_tgt);
    conn_t c;
    logic  bad_src;
    c           = '0;
    c.valid     = v;
    c.msg       = e[MSG_BIT];
    c.msg_byte  = e[7:0];
    if (!c.msg) begin
      c.local_src = e[SRC_BIT];
      c.src_top   = c.local_src ? lo_top : bp_top;
      if (c.src_top) begin
        c.stream = {1'b0, e[LOW_STREAM_HI:TOP_STREAM_LO]};
        c.chan   = e[8:0];
      end else begin
        c.stream = e[LOW_STREAM_HI:LOW_STREAM_LO];
        c.chan   = {1'b0, e[7:0]};
      end
    end
    // Source port and stream stay zero in message mode so nothing downstream can act on them.
    bad_src = !c.msg && !map_ok(c.stream, c.chan, c.src_top);
    c.fetch = v && !c.msg && !bad_src && !bad_tgt;
    c.drive = e[ON_BIT] && !bad_src && !bad_tgt;
    decode  = c;
  endfunction

  // ----------------------------------------------------------------
  // Map storage
  // ----------------------------------------------------------------
  logic [ENTRY_W-1:0]   map_mem [MAP_ENTRIES];
  logic [ENTRY_W-1:0]   host_word_q;
  logic [ENTRY_W-1:0]   slot_word_q;
  logic [4:0]           host_stream;
  logic                 host_ok;
  logic [MAP_IDX_W-1:0] host_idx;
  logic [MAP_IDX_W-1:0] slot_idx;
  logic                 slot_bad;

  assign host_stream = host.addr[ADDR_W-1:ADDR_STREAM_LO];
  assign host_ok     = map_ok(host_stream, host.addr[8:0], out_top_rate);
  assign host_idx    = map_index(host_stream, host.addr[8:0], out_top_rate);
  // At 32 Mbps streams 8 to 15 alias streams 0 to 7 in the index.
  // The slot_bad flag keeps those aliased slots from driving or fetching.
  assign slot_idx    = map_index({1'b0, slot_stream}, slot_chan, out_top_rate);
  assign slot_bad    = !map_ok({1'b0, slot_stream}, slot_chan, out_top_rate);

  // Storage has no reset; software fills the map before enabling any channel.
  always_ff @(posedge clock) begin
    if (host.wr && host_ok) begin
      map_mem[host_idx] <= host.wdata;
    end
    host_word_q <= map_mem[host_idx];
    slot_word_q <= map_mem[slot_idx];
  end

  // ----------------------------------------------------------------
  // Host reads and timeslot lookup
  // ----------------------------------------------------------------
  map_state_t q;
  map_state_t d;
  logic [7:0] load_byte;

  assign load_byte = q.conn.msg ? q.conn.msg_byte : sw_data;

  always_comb begin
    d        = q;
    d.fm_s1  = output_float_mode_pin;
    d.fm_s2  = q.fm_s1;
    d.hrd_v  = host.rd;
    d.hrd_ok = host_ok;
    d.rd_ack = q.hrd_v;
    // A refused address reads as zero; the host gets no other sign of it.
    if (q.hrd_v) begin
      d.rd_data = q.hrd_ok ? host_word_q : MAP_RESET;
    end
    d.lk_v   = slot_req;
    d.lk_bad = slot_bad;
    d.conn   = decode(slot_word_q, bp_top_rate, lo_top_rate, q.lk_v, q.lk_bad);
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign rd_ack  = q.rd_ack;
  assign rd_data = q.rd_data;
  assign conn    = q.conn;

  // ----------------------------------------------------------------
  // Serial output of one timeslot
  // ----------------------------------------------------------------
  slot_shifter shifter (
    .clock       (clock),
    .rst_n       (rst_n),
    .load        (q.conn.valid),
    .load_byte   (load_byte),
    .load_drive  (q.conn.drive),
    .float_mode  (q.fm_s2),
    .bit_tick    (bit_tick),
    .ser_data    (ser_data),
    .ser_oe      (ser_oe),
    .ext_buf_off (ext_buf_off)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  host_read_ack_a: assert property (host.rd |-> ##2 rd_ack) else $error("read not answered in two cycles");
  msg_no_fetch_a: assert property (conn.valid && conn.msg |-> !conn.fetch && conn.stream == 5'h00)
    else $error("message slot requested switched data");
  port_choice_a: assert property (conn.fetch |-> conn.local_src == $past(slot_word_q[SRC_BIT]))
    else $error("source port differs from bit 15");
  msg_byte_a: assert property (conn.valid && conn.msg |-> conn.msg_byte == $past(slot_word_q[7:0]))
    else $error("message byte differs from entry");
  float_bit_a: assert property (conn.valid && !$past(slot_word_q[ON_BIT]) |-> !conn.drive)
    else $error("channel driven with bit 13 low");
  low_stream_a: assert property (conn.fetch && !conn.src_top |-> conn.stream == $past(slot_word_q[12:8]))
    else $error("low rate stream field wrong");
  low_chan_a: assert property (conn.fetch && !conn.src_top |-> conn.chan[7:0] == $past(slot_word_q[7:0]))
    else $error("low rate channel field wrong");
  top_stream_a: assert property (conn.fetch && conn.src_top |-> conn.stream[3:0] == $past(slot_word_q[12:9]))
    else $error("top rate stream field wrong");
  top_chan_a: assert property (conn.fetch && conn.src_top |-> conn.chan == $past(slot_word_q[8:0]))
    else $error("top rate channel field wrong");
  top_unused_a: assert property (slot_req && out_top_rate && slot_stream > 4'h7 |-> ##2 !conn.drive && !conn.fetch)
    else $error("unused top rate stream active");
  msb_first_a: assert property (conn.valid |=> ser_data == $past(load_byte[7]))
    else $error("first bit is not bit 7");
  mode_bit_a: assert property (conn.valid |-> conn.msg == $past(slot_word_q[MSG_BIT]))
    else $error("mode differs from bit 14");

  // Lookup checks compare against the word fetched one cycle earlier, hence the $past terms.
  slot_answer_a: assert property (slot_req |-> ##2 conn.valid)
    else $error("slot lookup not answered in two cycles");
  rd_hold_a: assert property (!rd_ack |-> $stable(rd_data))
    else $error("read data changed without an answer");
  rd_refused_a: assert property (host.rd && !host_ok |-> ##2 rd_data == MAP_RESET)
    else $error("refused read did not return zero");
  fetch_src_ok_a: assert property (conn.fetch |-> (conn.src_top ? conn.stream <= TOP_STREAM_MAX : conn.stream <= STREAM_LIMIT))
    else $error("fetch from an unused source stream");
  src_rate_a: assert property (conn.fetch |-> conn.src_top == (conn.local_src ? $past(lo_top_rate) : $past(bp_top_rate)))
    else $error("source layout does not follow source rate");
  msg_src_clear_a: assert property (conn.valid && conn.msg |-> !conn.local_src && !conn.src_top && conn.chan == 9'h000)
    else $error("message slot kept source fields");
  msg_drive_a: assert property (conn.valid && conn.msg && !$past(q.lk_bad) |-> conn.drive == $past(slot_word_q[ON_BIT]))
    else $error("message slot enable differs from bit 13");
  drive_oe_a: assert property (conn.valid && conn.drive |=> ser_oe && !ext_buf_off)
    else $error("driven channel not enabled");
  float_ext_a: assert property (conn.valid && !conn.drive && q.fm_s2 |=> ser_oe && ext_buf_off)
    else $error("external buffer not told to float");
  float_pin_a: assert property (conn.valid && !conn.drive && !q.fm_s2 |=> !ser_oe && !ext_buf_off)
    else $error("floated channel still driven");

  // ----------------------------------------------------------------
  // Cover points
  // ----------------------------------------------------------------
  msg_slot_c: cover property (conn.valid && conn.msg && conn.drive);
  top_fetch_c: cover property (conn.fetch && conn.src_top);
  ext_float_c: cover property (ext_buf_off);
  pin_float_c: cover property (conn.valid && !conn.drive && !q.fm_s2);
  refused_read_c: cover property (host.rd && !host_ok);

endmodule

// *** tb/sw_source_model.sv ***
`timescale 1ns/1ns
module sw_source_model
  import local_switch_map_pkg::*;
(
  input  wire local_switch_map_pkg::conn_t conn,
  output logic [7:0]                       sw_data
);
  // ----------------------------------------------------------------
  // Data memories seen through the switch
  // ----------------------------------------------------------------
  logic [7:0] byte_v;
  // Each source port gives its own pattern, so a wrong port choice shows.
  assign byte_v = {conn.chan[3:0], conn.local_src, conn.stream[2:0]} ^ 8'h3c;
  // Outside the fetch cycle the byte is inverted, so a stray sample is caught.
  assign sw_data = conn.fetch ? byte_v : ~byte_v;
endmodule

// *** tb/local_switch_map_tb.sv ***
`timescale 1ns/1ns
module local_switch_map_tb;
  import local_switch_map_pkg::*;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  host_req_t   host = '0;
  logic        out_top_rate = 1'b0, bp_top_rate = 1'b0, lo_top_rate = 1'b0;
  logic        slot_req = 1'b0, bit_tick = 1'b0, float_pin = 1'b0;
  logic [3:0]  slot_stream = 4'h0;
  logic [8:0]  slot_chan = 9'h000;
  logic [7:0]  sw_data;
  logic        rd_ack, ser_data, ser_oe, ext_buf_off;
  logic [15:0] rd_data;
  conn_t       conn;
  int          miscompares = 0;
  int          comparisons = 0;

  always #5 clock = ~clock;

  local_switch_map u_local_switch_map (
    .clock(clock), .rst_n(rst_n), .host(host), .rd_ack(rd_ack), .rd_data(rd_data),
    .out_top_rate(out_top_rate), .bp_top_rate(bp_top_rate), .lo_top_rate(lo_top_rate),
    .slot_req(slot_req), .slot_stream(slot_stream), .slot_chan(slot_chan), .conn(conn),
    .sw_data(sw_data), .bit_tick(bit_tick), .output_float_mode_pin(float_pin),
    .ser_data(ser_data), .ser_oe(ser_oe), .ext_buf_off(ext_buf_off));

  sw_source_model u_sw_source_model (.conn(conn), .sw_data(sw_data));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic close_out;
    if (miscompares == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic ok, input string msg);
    comparisons++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask

  task automatic host_wr(input logic [4:0] s, input logic [8:0] c, input logic [15:0] d);
    @(posedge clock);
    host <= '{1'b0, 1'b1, {s, c}, d};
    @(posedge clock);
    host <= '0;
  endtask

  task automatic host_rd(input logic [4:0] s, input logic [8:0] c, input logic [15:0] exp, input string msg);
    int n;
    @(posedge clock);
    host <= '{1'b1, 1'b0, {s, c}, 16'h0000};
    @(posedge clock);
    host <= '0;
    for (n = 0; n < 6 && rd_ack !== 1'b1; n++) begin
      @(posedge clock);
      #1;
    end
    if (rd_ack !== 1'b1) begin
      miscompares++;
      $display("MISMATCH %0t read answer missing", $time);
      close_out();
    end
    chk(rd_data === exp, msg);
  endtask

  // A floated slot carries no checked data; its fetch flag is left open.
  task automatic slot_run(input logic [3:0] s, input logic [8:0] c, input logic bits, input logic f,
                          input logic drv, input logic oe, input logic ext, input logic [7:0] b);
    @(posedge clock);
    slot_req <= 1'b1;
    slot_stream <= s;
    slot_chan <= c;
    @(posedge clock);
    slot_req <= 1'b0;
    @(posedge clock);
    #1;
    chk(conn.valid === 1'b1 && conn.drive === drv && (conn.fetch === f || !bits), "lookup answer");
    @(posedge clock);
    #1;
    chk(ser_oe === oe && ext_buf_off === ext, "output enable");
    for (int i = 7; i >= 0; i--) begin
      if (bits) begin
        chk(ser_data === b[i], "serial bit");
      end
      @(posedge clock);
      bit_tick <= 1'b1;
      @(posedge clock);
      bit_tick <= 1'b0;
      #1;
    end
    chk(ser_oe === 1'b0 && ext_buf_off === 1'b0, "release after slot");
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_map;
    host_wr(5'h0f, 9'h0ff, 16'h1234);
    host_rd(5'h0f, 9'h0ff, 16'h1234, "low-rate readback");
    host_wr(5'h00, 9'h100, 16'hbeef);
    host_rd(5'h00, 9'h100, 16'h0000, "low-rate channel above 255");
    host_rd(5'h10, 9'h000, 16'h0000, "stream above 15");
    @(posedge clock);
    out_top_rate <= 1'b1;
    host_wr(5'h07, 9'h1ff, 16'h5678);
    host_rd(5'h07, 9'h1ff, 16'h5678, "top-rate readback");
    host_rd(5'h08, 9'h000, 16'h0000, "top-rate stream 8");
    @(posedge clock);
    out_top_rate <= 1'b0;
    host_rd(5'h0f, 9'h0ff, 16'h5678, "one shared map");
  endtask

  task automatic t_msg;
    host_wr(5'h01, 9'h004, 16'hffa5);
    slot_run(4'h1, 9'h004, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 8'ha5);
    chk(conn.msg === 1'b1 && conn.msg_byte === 8'ha5, "message fields");
    chk(conn.local_src === 1'b0 && conn.stream === 5'h00 && conn.chan === 9'h000, "ignored fields");
  endtask

  task automatic t_low;
    host_wr(5'h01, 9'h005, 16'h2342);
    slot_run(4'h1, 9'h005, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, {4'h2, 1'b0, 3'h3} ^ 8'h3c);
    chk(conn.msg === 1'b0 && conn.local_src === 1'b0 && conn.src_top === 1'b0, "low source mode");
    chk(conn.stream === 5'h03 && conn.chan === 9'h042, "low source address");
  endtask

  task automatic t_top;
    @(posedge clock);
    lo_top_rate <= 1'b1;
    host_wr(5'h01, 9'h006, 16'haba3);
    slot_run(4'h1, 9'h006, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, {4'h3, 1'b1, 3'h5} ^ 8'h3c);
    chk(conn.src_top === 1'b1 && conn.local_src === 1'b1, "top source mode");
    chk(conn.stream === 5'h05 && conn.chan === 9'h1a3, "top source address");
  endtask

  task automatic t_float;
    host_wr(5'h01, 9'h007, 16'h0210);
    slot_run(4'h1, 9'h007, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00);
    @(posedge clock);
    float_pin <= 1'b1;
    slot_run(4'h1, 9'h007, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 8'h00);
    @(posedge clock);
    out_top_rate <= 1'b1;
    host_wr(5'h01, 9'h000, 16'h2210);
    slot_run(4'h1, 9'h000, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, {4'h0, 1'b0, 3'h2} ^ 8'h3c);
    slot_run(4'h9, 9'h000, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 8'h00);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    #1;
    chk(rd_ack === 1'b0 && rd_data === 16'h0000 && ser_oe === 1'b0 && conn === '0, "reset values");
    t_map();
    t_msg();
    t_low();
    t_top();
    t_float();
    close_out();
  end
endmodule
